// ==== verilog/ette_regs.vh ====
// Register map, field positions, reset values and record layout of the transfer engine
`ifndef ETTE_REGS_VH
`define ETTE_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ETTE_OFS_ENABLE   12'h000
`define ETTE_OFS_CONTROL  12'h004
`define ETTE_OFS_VBASE    12'h008
`define ETTE_OFS_STATUS   12'h00c

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ETTE_RST_ENABLE   16'h0000
`define ETTE_RST_CONTROL  8'h00
`define ETTE_RST_VBASE    32'h00000000

// ----------------------------------------
// Engine control bits
// ----------------------------------------
`define ETTE_CTL_RSKIP    0
`define ETTE_CTL_PRIO     1
`define ETTE_CTL_CLREN    2

// ----------------------------------------
// Vector table and record layout
// ----------------------------------------
`define ETTE_VEC_OFS      32'h00000400
`define ETTE_REC_STRIDE   32'h00000010
`define ETTE_REC_WORDS    2'd3

// ----------------------------------------
// Mode field codes
// ----------------------------------------
`define ETTE_MD_NORMAL    2'b00
`define ETTE_MD_REPEAT    2'b01
`define ETTE_MD_BLOCK     2'b10
`define ETTE_AM_INC       2'b10
`define ETTE_AM_DEC       2'b11
`define ETTE_SZ_WORD      2'b01

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define ETTE_RESP_OKAY    2'b00
`define ETTE_RESP_SLVERR  2'b10

`endif

// ==== verilog/ette_engine.v ====
// Event-triggered transfer engine with AXI4-Lite registers and a memory bus master
`timescale 1ns/100ps
`include "ette_regs.vh"

module ette_engine #(
  parameter       NSRC      = 16,
  parameter       AW        = 12,
  parameter [7:0] VEC_FIRST = 8'h00
) (
  // Clock and reset
  input  wire             sys_clk_i,
  input  wire             rstn_i,
  // AXI4-Lite slave
  input  wire [AW-1:0]    s_axi_awaddr_i,
  input  wire             s_axi_awvalid_i,
  output wire             s_axi_awready_o,
  input  wire [31:0]      s_axi_wdata_i,
  input  wire [3:0]       s_axi_wstrb_i,
  input  wire             s_axi_wvalid_i,
  output wire             s_axi_wready_o,
  output reg  [1:0]       s_axi_bresp_o,
  output reg              s_axi_bvalid_o,
  input  wire             s_axi_bready_i,
  input  wire [AW-1:0]    s_axi_araddr_i,
  input  wire             s_axi_arvalid_i,
  output wire             s_axi_arready_o,
  output reg  [31:0]      s_axi_rdata_o,
  output reg  [1:0]       s_axi_rresp_o,
  output reg              s_axi_rvalid_o,
  input  wire             s_axi_rready_i,
  // Peripheral requests and processor interrupts
  input  wire [NSRC-1:0]  act_req_i,
  output reg  [NSRC-1:0]  cpu_irq_o,
  // Internal bus arbitration
  output reg              bus_req_o,
  input  wire             bus_gnt_i,
  // Internal memory bus
  output reg              mem_req_o,
  output reg              mem_we_o,
  output reg  [31:0]      mem_addr_o,
  output reg  [1:0]       mem_size_o,
  output reg  [31:0]      mem_wdata_o,
  input  wire             mem_ack_i,
  input  wire [31:0]      mem_rdata_i
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'd0;
  localparam [3:0] ST_GNT  = 4'd1;
  localparam [3:0] ST_VEC  = 4'd2;
  localparam [3:0] ST_REC  = 4'd3;
  localparam [3:0] ST_RD   = 4'd4;
  localparam [3:0] ST_WR   = 4'd5;
  localparam [3:0] ST_UPD  = 4'd6;
  localparam [3:0] ST_WB   = 4'd7;
  localparam [3:0] ST_FIN  = 4'd8;

  reg  [15:0]     en_q;
  reg  [7:0]      ctl_q;
  reg  [31:0]     vbr_q;
  reg  [3:0]      st_q;
  reg  [3:0]      src_q;
  reg  [3:0]      last_src_q;
  reg             rec_ok_q;
  reg             chained_q;
  reg  [31:0]     rec_q;
  reg  [1:0]      idx_q;
  reg  [7:0]      mra_q;
  reg  [7:0]      mrb_q;
  reg  [31:0]     sar_q;
  reg  [31:0]     dar_q;
  reg  [15:0]     cra_q;
  reg  [15:0]     crb_q;
  reg  [31:0]     dbuf_q;
  reg             last_q;
  reg             irq_q;
  reg             clr_q;
  reg  [NSRC-1:0] s1_q;
  reg  [NSRC-1:0] s2_q;
  reg  [NSRC-1:0] hold_q;

  // ----------------------------------------
  // Request synchronisers and arbitration
  // ----------------------------------------
  wire [NSRC-1:0] elig = s2_q & en_q[NSRC-1:0] & ~hold_q;
  reg  [3:0]      pick;
  reg             found;
  reg  [3:0]      base;
  reg  [3:0]      cand;
  integer         k;

  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_src
      always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          s1_q[g]   <= 1'b0;
          s2_q[g]   <= 1'b0;
          hold_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= act_req_i[g];
          s2_q[g] <= s1_q[g];
          // Served request stays masked until the peripheral drops it
          if (st_q == ST_IDLE && found && pick == g)
            hold_q[g] <= 1'b1;
          else if (!s2_q[g])
            hold_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always @* begin
    base  = ctl_q[`ETTE_CTL_PRIO] ? last_src_q + 4'd1 : 4'd0;
    pick  = 4'd0;
    found = 1'b0;
    cand  = 4'd0;
    for (k = 0; k < 16; k = k + 1) begin
      cand = base + k[3:0];
      if (!found && cand < NSRC && elig[cand]) begin
        found = 1'b1;
        pick  = cand;
      end
    end
  end

  // ----------------------------------------
  // Address step helpers
  // ----------------------------------------
  wire [1:0]  sz   = mra_q[5:4];
  wire [1:0]  md   = mra_q[7:6];
  wire [1:0]  sm   = mra_q[3:2];
  wire [1:0]  dm   = mrb_q[3:2];
  wire        repeat_side_select  = mrb_q[4];
  wire [31:0] step = (sz == 2'b00) ? 32'h1 : (sz == `ETTE_SZ_WORD) ? 32'h2 : 32'h4;
  wire [31:0] span = {24'h0, cra_q[15:8]} << sz;

  function [31:0] adv;
    input [31:0] a;
    input [1:0]  m;
    input [31:0] s;
    begin
      if (m == `ETTE_AM_INC)
        adv = a + s;
      else if (m == `ETTE_AM_DEC)
        adv = a - s;
      else
        adv = a;
    end
  endfunction

  wire [31:0] sa1 = adv(sar_q, sm, step);
  wire [31:0] da1 = adv(dar_q, dm, step);
  wire [31:0] sa0 = adv(sa1, {sm[1], ~sm[0]}, span);
  wire [31:0] da0 = adv(da1, {dm[1], ~dm[0]}, span);
  wire        wrap = (cra_q[7:0] == 8'h01);
  wire        skip = ctl_q[`ETTE_CTL_RSKIP] && rec_ok_q && (pick == last_src_q);

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  task issue;
    input        we;
    input [31:0] a;
    input [31:0] d;
    input [1:0]  s;
    begin
      mem_req_o   <= 1'b1;
      mem_we_o    <= we;
      mem_addr_o  <= a;
      mem_wdata_o <= d;
      mem_size_o  <= s;
    end
  endtask

  wire done = mem_req_o && mem_ack_i;

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q       <= ST_IDLE;
      src_q      <= 4'd0;
      last_src_q <= 4'd0;
      rec_ok_q   <= 1'b0;
      chained_q  <= 1'b0;
      rec_q      <= 32'h0;
      idx_q      <= 2'd0;
      mra_q      <= 8'h00;
      mrb_q      <= 8'h00;
      sar_q      <= 32'h0;
      dar_q      <= 32'h0;
      cra_q      <= 16'h0;
      crb_q      <= 16'h0;
      dbuf_q     <= 32'h0;
      last_q     <= 1'b0;
      irq_q      <= 1'b0;
      clr_q      <= 1'b0;
      bus_req_o  <= 1'b0;
      mem_req_o  <= 1'b0;
      mem_we_o   <= 1'b0;
      mem_addr_o <= 32'h0;
      mem_wdata_o <= 32'h0;
      mem_size_o <= 2'b00;
    end else begin
      if (done)
        mem_req_o <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          chained_q <= 1'b0;
          if (found) begin
            src_q     <= pick;
            bus_req_o <= 1'b1;
            st_q      <= ST_GNT;
            if (!skip)
              rec_ok_q <= 1'b0;
          end
        end
        ST_GNT: begin
          if (bus_gnt_i) begin
            if (rec_ok_q) begin
              st_q <= ST_RD;
            end else begin
              st_q <= ST_VEC;
              issue(1'b0, vbr_q + `ETTE_VEC_OFS + {22'h0, VEC_FIRST + {4'h0, src_q}, 2'b00},
                    32'h0, 2'b10);
            end
          end
        end
        ST_VEC: begin
          if (done) begin
            rec_q <= mem_rdata_i;
            idx_q <= 2'd0;
            st_q  <= ST_REC;
          end
        end
        ST_REC: begin
          if (!mem_req_o) begin
            issue(1'b0, rec_q + {28'h0, idx_q, 2'b00}, 32'h0, 2'b10);
          end else if (done) begin
            case (idx_q)
              2'd0: begin
                mra_q <= mem_rdata_i[31:24];
                mrb_q <= mem_rdata_i[23:16];
              end
              2'd1: sar_q <= mem_rdata_i;
              2'd2: dar_q <= mem_rdata_i;
              default: begin
                cra_q <= mem_rdata_i[31:16];
                crb_q <= mem_rdata_i[15:0];
              end
            endcase
            idx_q <= idx_q + 2'd1;
            if (idx_q == `ETTE_REC_WORDS)
              st_q <= ST_RD;
          end
        end
        ST_RD: begin
          if (!mem_req_o) begin
            issue(1'b0, sar_q, 32'h0, sz);
          end else if (done) begin
            dbuf_q <= mem_rdata_i;
            st_q   <= ST_WR;
          end
        end
        ST_WR: begin
          if (!mem_req_o) begin
            issue(1'b1, dar_q, dbuf_q, sz);
          end else if (done) begin
            st_q <= ST_UPD;
          end
        end
        ST_UPD: begin
          sar_q  <= sa1;
          dar_q  <= da1;
          idx_q  <= 2'd1;
          st_q   <= ST_WB;
          if (md == `ETTE_MD_NORMAL) begin
            cra_q  <= cra_q - 16'd1;
            last_q <= (cra_q == 16'd1);
          end else begin
            cra_q[7:0] <= wrap ? cra_q[15:8] : cra_q[7:0] - 8'd1;
            if (wrap) begin
              if (repeat_side_select)
                dar_q <= da0;
              else
                sar_q <= sa0;
            end
            if (md == `ETTE_MD_BLOCK) begin
              if (wrap)
                crb_q <= crb_q - 16'd1;
              last_q <= wrap && (crb_q == 16'd1);
              if (!wrap)
                st_q <= ST_RD;
            end else begin
              last_q <= wrap;
            end
          end
        end
        ST_WB: begin
          if (!mem_req_o && !done) begin
            if (idx_q == 2'd1 && !sm[1])
              idx_q <= 2'd2;
            else if (idx_q == 2'd2 && !dm[1])
              idx_q <= 2'd3;
            else
              issue(1'b1, rec_q + {28'h0, idx_q, 2'b00},
                    (idx_q == 2'd1) ? sar_q : (idx_q == 2'd2) ? dar_q : {cra_q, crb_q},
                    2'b10);
          end else if (done) begin
            idx_q <= idx_q + 2'd1;
            if (idx_q == `ETTE_REC_WORDS) begin
              irq_q <= mrb_q[5] || (last_q && md != `ETTE_MD_REPEAT);
              clr_q <= ctl_q[`ETTE_CTL_CLREN] || (last_q && md != `ETTE_MD_REPEAT);
              if (mrb_q[7] && last_q) begin
                chained_q <= 1'b1;
                rec_q     <= rec_q + `ETTE_REC_STRIDE;
                idx_q     <= 2'd0;
                st_q      <= ST_REC;
              end else begin
                st_q <= ST_FIN;
              end
            end
          end
        end
        ST_FIN: begin
          bus_req_o  <= 1'b0;
          last_src_q <= src_q;
          rec_ok_q   <= !chained_q;
          st_q       <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Processor interrupts
  // ----------------------------------------
  wire fin = (st_q == ST_FIN);

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      cpu_irq_o <= {NSRC{1'b0}};
    else
      cpu_irq_o <= (s2_q & ~en_q[NSRC-1:0]) |
                   ({{(NSRC-1){1'b0}}, fin & irq_q} << src_q);
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  reg           aw_full_q;
  reg  [AW-1:0] aw_q;
  reg           w_full_q;
  reg  [31:0]   w_q;
  reg  [3:0]    ws_q;
  wire          wr_go = aw_full_q && w_full_q && !s_axi_bvalid_o;
  wire [31:0]   wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  wire [15:0]   hw_clr = (fin && clr_q) ? (16'h1 << src_q) : 16'h0;

  assign s_axi_awready_o = !aw_full_q;
  assign s_axi_wready_o  = !w_full_q;
  assign s_axi_arready_o = !s_axi_rvalid_o;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] msk;
    begin
      merge = (old & ~msk) | (nw & msk);
    end
  endfunction

  // Full-word merges; only the register's own low bits are kept
  wire [31:0]   en_new  = merge({16'h0, en_q}, w_q, wmask);
  wire [31:0]   ctl_new = merge({24'h0, ctl_q}, w_q, wmask);

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_full_q      <= 1'b0;
      aw_q           <= {AW{1'b0}};
      w_full_q       <= 1'b0;
      w_q            <= 32'h0;
      ws_q           <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `ETTE_RESP_OKAY;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o  <= `ETTE_RESP_OKAY;
      s_axi_rdata_o  <= 32'h0;
      en_q           <= `ETTE_RST_ENABLE;
      ctl_q          <= `ETTE_RST_CONTROL;
      vbr_q          <= `ETTE_RST_VBASE;
    end else begin
      en_q <= en_q & ~hw_clr;
      if (s_axi_awvalid_i && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_q      <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_full_q) begin
        w_full_q <= 1'b1;
        w_q      <= s_axi_wdata_i;
        ws_q     <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_full_q      <= 1'b0;
        w_full_q       <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= `ETTE_RESP_OKAY;
        case (aw_q[AW-1:2])
          `ETTE_OFS_ENABLE >> 2:
            en_q <= en_new[15:0] & ~hw_clr;
          `ETTE_OFS_CONTROL >> 2:
            ctl_q <= ctl_new[7:0];
          `ETTE_OFS_VBASE >> 2:
            vbr_q <= merge(vbr_q, w_q, wmask);
          `ETTE_OFS_STATUS >> 2: ;
          default: s_axi_bresp_o <= `ETTE_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o  <= `ETTE_RESP_OKAY;
        case (s_axi_araddr_i[AW-1:2])
          `ETTE_OFS_ENABLE >> 2:  s_axi_rdata_o <= {16'h0, en_q};
          `ETTE_OFS_CONTROL >> 2: s_axi_rdata_o <= {24'h0, ctl_q};
          `ETTE_OFS_VBASE >> 2:   s_axi_rdata_o <= vbr_q;
          `ETTE_OFS_STATUS >> 2:
            s_axi_rdata_o <= {23'h0, bus_req_o, st_q, src_q};
          default: begin
            s_axi_rdata_o <= 32'h0;
            s_axi_rresp_o <= `ETTE_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

endmodule

// ==== verif/ette_engine_sva.sv ====
// Port-level assertions for the transfer engine, bound to its top module
`timescale 1ns/100ps
module ette_engine_sva (
  // Clock and reset
  input wire        sys_clk_i,
  input wire        rstn_i,
  // Register bus answers
  input wire        s_axi_bvalid_o,
  input wire        s_axi_bready_i,
  input wire [1:0]  s_axi_bresp_o,
  input wire        s_axi_rvalid_o,
  input wire        s_axi_rready_i,
  input wire [31:0] s_axi_rdata_o,
  // Arbitration and memory bus
  input wire        bus_req_o,
  input wire        bus_gnt_i,
  input wire        mem_req_o,
  input wire        mem_we_o,
  input wire [31:0] mem_addr_o,
  input wire [1:0]  mem_size_o,
  input wire [31:0] mem_wdata_o,
  input wire        mem_ack_i
);
  default clocking dck @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_mem_needs_grant;
    mem_req_o |-> bus_req_o && bus_gnt_i;
  endproperty
  a_mem_needs_grant: assert property (p_mem_needs_grant)
    else $error("memory access without bus grant");

  property p_wait_grant;
    bus_req_o && !bus_gnt_i |=> bus_req_o;
  endproperty
  a_wait_grant: assert property (p_wait_grant)
    else $error("bus request dropped before grant");

  property p_grant_starts;
    $rose(bus_gnt_i) |-> ##[0:2] mem_req_o;
  endproperty
  a_grant_starts: assert property (p_grant_starts)
    else $error("no memory access after grant");

  property p_req_holds;
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o)
      && $stable(mem_size_o) && $stable(mem_wdata_o);
  endproperty
  a_req_holds: assert property (p_req_holds)
    else $error("memory request changed before ack");

  property p_unit_aligned;
    mem_req_o |-> mem_size_o != 2'b11 && (mem_size_o != 2'b01 || !mem_addr_o[0])
      && (mem_size_o != 2'b10 || mem_addr_o[1:0] == 2'b00);
  endproperty
  a_unit_aligned: assert property (p_unit_aligned)
    else $error("illegal or misaligned transfer unit");

  property p_gap_after_ack;
    mem_ack_i |=> !mem_req_o;
  endproperty
  a_gap_after_ack: assert property (p_gap_after_ack)
    else $error("no idle cycle after memory ack");

  property p_release_after_wb;
    $fell(bus_req_o) |-> !mem_req_o && !$past(mem_req_o);
  endproperty
  a_release_after_wb: assert property (p_release_after_wb)
    else $error("bus released during an access");

  property p_b_holds;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_b_holds: assert property (p_b_holds)
    else $error("write response not held");

  property p_r_holds;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_r_holds: assert property (p_r_holds)
    else $error("read data not held");
endmodule

bind ette_engine ette_engine_sva i_sva (
  .sys_clk_i      (sys_clk_i),
  .rstn_i         (rstn_i),
  .s_axi_bvalid_o (s_axi_bvalid_o),
  .s_axi_bready_i (s_axi_bready_i),
  .s_axi_bresp_o  (s_axi_bresp_o),
  .s_axi_rvalid_o (s_axi_rvalid_o),
  .s_axi_rready_i (s_axi_rready_i),
  .s_axi_rdata_o  (s_axi_rdata_o),
  .bus_req_o      (bus_req_o),
  .bus_gnt_i      (bus_gnt_i),
  .mem_req_o      (mem_req_o),
  .mem_we_o       (mem_we_o),
  .mem_addr_o     (mem_addr_o),
  .mem_size_o     (mem_size_o),
  .mem_wdata_o    (mem_wdata_o),
  .mem_ack_i      (mem_ack_i)
);

// ==== verif/ette_bus_model.sv ====
// Memory, bus arbiter and requesting converter on the engine's far side
`timescale 1ns/100ps
module ette_bus_model #(
  parameter [31:0] RES_PAGE = 32'h00008000
) (
  // Clock, reset and pacing
  input  wire        clk_i,
  input  wire        rstn_i,
  input  wire [1:0]  lat_i,
  // Converter requests
  input  wire [15:0] start_i,
  output reg  [15:0] act_req_o,
  // Arbitration and memory bus
  input  wire        bus_req_i,
  output reg         bus_gnt_o,
  input  wire        mem_req_i,
  input  wire        mem_we_i,
  input  wire [31:0] mem_addr_i,
  input  wire [31:0] mem_wdata_i,
  output reg         mem_ack_o,
  output reg  [31:0] mem_rdata_o
);
  logic [31:0] mem [logic [31:0]];
  bit          written [logic [31:0]];
  reg   [1:0]  wait_q;

  // Grant and acks come lat_i cycles late; idle read data toggles every cycle
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act_req_o   <= 16'h0;
      bus_gnt_o   <= 1'b0;
      mem_ack_o   <= 1'b0;
      mem_rdata_o <= 32'h0;
      wait_q      <= 2'h0;
    end else begin
      act_req_o   <= act_req_o | start_i;
      mem_ack_o   <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (!bus_req_i) begin
        bus_gnt_o <= 1'b0;
      end else if (!bus_gnt_o || (mem_req_i && !mem_ack_o)) begin
        wait_q <= wait_q + 2'h1;
        if (wait_q >= lat_i) begin
          wait_q    <= 2'h0;
          bus_gnt_o <= 1'b1;
          mem_ack_o <= bus_gnt_o;
          if (bus_gnt_o && mem_we_i) begin
            mem[mem_addr_i]     = mem_wdata_i;
            written[mem_addr_i] = 1'b1;
          end else if (bus_gnt_o) begin
            mem_rdata_o <= mem.exists(mem_addr_i) ? mem[mem_addr_i] : ~mem_addr_i;
            if (mem_addr_i[31:8] == RES_PAGE[31:8])
              act_req_o[mem_addr_i[5:2]] <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// ==== verif/test_event_triggered_transfer_engine.sv ====
// Self-checking bench for the event-triggered transfer engine
`timescale 1ns/100ps
`include "ette_regs.vh"
module test_event_triggered_transfer_engine;
  reg         sys_clk_i = 1'b0;
  reg         rstn_i = 1'b0;
  reg  [11:0] awaddr = 12'h0;
  reg  [11:0] araddr = 12'h0;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'b0;
  reg         wvalid = 1'b0;
  reg         bready = 1'b0;
  reg         arvalid = 1'b0;
  reg         rready = 1'b0;
  reg  [1:0]  lat = 2'h0;
  reg  [15:0] start = 16'h0;
  wire        awready, wready, bvalid, arready, rvalid;
  wire        bus_req, bus_gnt, mem_req, mem_we, mem_ack;
  wire [1:0]  bresp, rresp, mem_size;
  wire [31:0] rdata, mem_addr, mem_wdata, mem_rdata;
  wire [15:0] act_req, cpu_irq;
  integer     miscompares = 0;
  integer     checks = 0;
  integer     cycles = 0;
  integer     irqs = 0;
  integer     seed = 53;
  reg  [3:0]  cur = 4'h0;
  reg  [31:0] vb, d, w;
  reg  [11:0] a;
  reg  [1:0]  r;

  always #4 sys_clk_i = ~sys_clk_i;

  ette_engine #(.NSRC(16), .AW(12), .VEC_FIRST(8'h00)) i_dut (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .act_req_i(act_req),
    .cpu_irq_o(cpu_irq), .bus_req_o(bus_req), .bus_gnt_i(bus_gnt), .mem_req_o(mem_req),
    .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_size_o(mem_size),
    .mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata));

  ette_bus_model i_mdl (
    .clk_i(sys_clk_i), .rstn_i(rstn_i), .lat_i(lat), .start_i(start), .act_req_o(act_req),
    .bus_req_i(bus_req), .bus_gnt_o(bus_gnt), .mem_req_i(mem_req), .mem_we_i(mem_we),
    .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata), .mem_ack_o(mem_ack),
    .mem_rdata_o(mem_rdata));

  always @(posedge sys_clk_i) begin
    if (cpu_irq[cur] === 1'b1) irqs <= irqs + 1;
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  end

  task tally_and_finish;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  task chk(input [8*16:1] nm, input [31:0] exp, input [31:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        $display("MISMATCH %0s expected %h seen %h", nm, exp, got);
        miscompares = miscompares + 1;
      end
    end
  endtask

  // Handshakes are judged on values that stand before the next rising edge
  task axi_wr(input [11:0] ad, input [31:0] dt, output [1:0] rs);
    reg ta, tw, b;
    begin
      awaddr <= ad; wdata <= dt; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      ta = 1'b0; tw = 1'b0;
      do begin
        @(negedge sys_clk_i); ta = ta | awready; tw = tw | wready; b = bvalid; rs = bresp;
        @(posedge sys_clk_i); if (ta) awvalid <= 1'b0; if (tw) wvalid <= 1'b0;
      end while (b !== 1'b1);
      bready <= 1'b0;
      @(posedge sys_clk_i);
    end
  endtask

  task axi_rd(input [11:0] ad, output [31:0] dt, output [1:0] rs);
    reg ta, b;
    begin
      araddr <= ad; arvalid <= 1'b1; rready <= 1'b1; ta = 1'b0;
      do begin
        @(negedge sys_clk_i); ta = ta | arready; b = rvalid; dt = rdata; rs = rresp;
        @(posedge sys_clk_i); if (ta) arvalid <= 1'b0;
      end while (b !== 1'b1);
      rready <= 1'b0;
      @(posedge sys_clk_i);
    end
  endtask

  function [31:0] step(input [31:0] ad, input [1:0] m, input [31:0] dl);
    step = (m == `ETTE_AM_INC) ? ad + dl : (m == `ETTE_AM_DEC) ? ad - dl : ad;
  endfunction

  // Raises one request and waits until the engine has released the bus
  task fire(input [3:0] sn);
    begin
      start[sn] <= 1'b1;
      @(posedge sys_clk_i);
      start <= 16'h0;
      while (bus_req !== 1'b1) @(posedge sys_clk_i);
      while (bus_req !== 1'b0) @(posedge sys_clk_i);
      repeat (3) @(posedge sys_clk_i);
    end
  endtask

  // One activation from a random source, then the record is compared with its expected update
  task run_case(input [7:0] ma, input [7:0] mb, input [15:0] cnt, input [15:0] cb);
    reg [31:0] rec, sa, da, dat, nsa, nda, u, back;
    reg [15:0] nc, nb;
    reg [7:0]  n;
    reg [3:0]  s;
    reg [1:0]  ctl;
    reg        ex, due, clr;
    integer    i0;
    begin
      w = $random(seed); s = w[3:0]; ctl = w[5:4]; lat <= w[7:6];
      rec = 32'h2000 + {s, 5'h0};
      sa  = 32'h8000 + {s, 2'h0};
      da  = 32'h40000 + {16'h0, w[31:18], 2'h0};
      dat = $random(seed);
      axi_wr(`ETTE_OFS_CONTROL, {29'h0, ctl, 1'b0}, r);
      axi_wr(`ETTE_OFS_ENABLE, 32'hffff, r);
      i_mdl.mem[vb + `ETTE_VEC_OFS + {s, 2'h0}] = rec;
      i_mdl.mem[rec] = {ma, mb, 16'h0};
      i_mdl.mem[rec + 4] = sa;
      i_mdl.mem[rec + 8] = da;
      i_mdl.mem[rec + 12] = {cnt, cb};
      i_mdl.mem[rec + 16] = 32'h0;
      i_mdl.mem[rec + 20] = sa;
      i_mdl.mem[rec + 24] = da + 32'h100;
      i_mdl.mem[rec + 28] = 32'h00010000;
      i_mdl.mem[sa] = dat;
      i_mdl.written.delete();
      cur = s; i0 = irqs;
      fire(s);
      u    = 32'h1 << ma[5:4];
      n    = (ma[7:6] == `ETTE_MD_BLOCK) ? cnt[15:8] : 8'h1;
      back = 32'h0 - u * cnt[15:8];
      nsa  = step(sa, ma[3:2], u * n);
      nda  = step(da, mb[3:2], u * n);
      nc   = cnt - 16'h1;
      nb   = (ma[7:6] == `ETTE_MD_BLOCK) ? cb - 16'h1 : cb;
      if (ma[7:6] != `ETTE_MD_NORMAL) begin
        nc = {cnt[15:8], cnt[7:0] - n};
        if (nc[7:0] == 8'h0) begin
          nc[7:0] = cnt[15:8];
          if (mb[4]) nda = step(nda, mb[3:2], back);
          else nsa = step(nsa, ma[3:2], back);
        end
      end
      ex  = (ma[7:6] == `ETTE_MD_NORMAL && nc == 16'h0) || (ma[7:6] == `ETTE_MD_BLOCK && nb == 16'h0);
      due = mb[5] | ex;
      clr = ctl[1] | ex;
      chk("irq pulses", {31'h0, due}, irqs - i0);
      chk("src written", {31'h0, ma[3]}, i_mdl.written.exists(rec + 4));
      chk("dst written", {31'h0, mb[3]}, i_mdl.written.exists(rec + 8));
      if (ma[3]) chk("src address", nsa, i_mdl.mem[rec + 4]);
      if (mb[3]) chk("dst address", nda, i_mdl.mem[rec + 8]);
      chk("counts", {nc, nb}, i_mdl.mem[rec + 12]);
      if (mb[7]) chk("chained counts", 32'h0, i_mdl.mem[rec + 28]);
      if (ma[5:4] == 2'b10) chk("data", dat, i_mdl.mem[da]);
      axi_rd(`ETTE_OFS_ENABLE, d, r);
      chk("enable", 32'hffff ^ ({31'h0, clr} << s), d);
    end
  endtask

  initial begin
    repeat (16) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    for (a = 12'h0; a < `ETTE_OFS_STATUS; a = a + 12'h4) begin
      axi_rd(a, d, r);
      chk("reset value", 32'h0, d);
      w = $random(seed);
      axi_wr(a, w, r);
      axi_rd(a, d, r);
      chk("readback", w & (a == 12'h0 ? 32'hffff : a == 12'h4 ? 32'hff : 32'hffffffff), d);
    end
    axi_wr(12'h010, w, r);
    chk("unmapped bresp", {30'h0, `ETTE_RESP_SLVERR}, {30'h0, r});
    axi_rd(12'h010, d, r);
    chk("unmapped rresp", {30'h0, `ETTE_RESP_SLVERR}, {30'h0, r});
    chk("unmapped rdata", 32'h0, d);
    vb = $random(seed) & 32'h0ff00000;
    axi_wr(`ETTE_OFS_VBASE, vb, r);
    repeat (2) begin
      run_case(8'h20, 8'h28, 16'h0005, 16'h0000);
      run_case(8'h18, 8'h0c, 16'h0001, 16'h0000);
      run_case(8'h0c, 8'h08, 16'h0000, 16'h0000);
      run_case(8'h20, 8'h88, 16'h0001, 16'h0000);
      run_case(8'h58, 8'h08, 16'h0301, 16'h0000);
      run_case(8'h60, 8'h18, 16'h0403, 16'h0000);
      run_case(8'h88, 8'h18, 16'h0303, 16'h0002);
      run_case(8'h98, 8'h08, 16'h0202, 16'h0001);
    end
    // Same source again with reread skip: held counts must be used, not the poked record
    axi_wr(`ETTE_OFS_CONTROL, 32'h1, r);
    axi_wr(`ETTE_OFS_ENABLE, 32'hffff, r);
    i_mdl.mem[32'h2000 + {cur, 5'h0} + 12] = 32'hffffffff;
    fire(cur);
    chk("skip counts", 32'h0202ffff, i_mdl.mem[32'h2000 + {cur, 5'h0} + 12]);
    tally_and_finish;
  end
endmodule
